// file: rtl/sas_pkg.sv
// Purpose: shared constants for the 8-bit successive-approximation converter sequencer
// Assumes: 32-bit classic Wishbone register access, one clock at 125 MHz
// Notes: register offsets and interrupt register layout are local choices
package sas_pkg;
  localparam int SAS_AW = 4;
  // byte addresses of the word registers
  localparam logic [SAS_AW-1:0] SAS_OFS_RESULT = 4'h0;
  localparam logic [SAS_AW-1:0] SAS_OFS_CSR = 4'h4;
  localparam logic [SAS_AW-1:0] SAS_OFS_IRQ_STAT = 4'h8;
  localparam logic [SAS_AW-1:0] SAS_OFS_IRQ_MASK = 4'hC;
  // control/status field positions
  localparam int SAS_CSR_DONE_BIT = 7;
  localparam int SAS_CSR_ON_BIT = 5;
  localparam int SAS_CSR_CH_LSB = 0;
  localparam int SAS_CH_W = 4;
  localparam logic [7:0] SAS_CSR_RESET = 8'h00;
  localparam logic [7:0] SAS_RESULT_RESET = 8'h00;
  // converter timing
  localparam int SAS_CLK_DIV = 4;
  localparam int SAS_CONV_PERIODS = 12;
  localparam int SAS_APPROX_STEPS = 8;
  localparam int SAS_LOAD_PERIODS = SAS_CONV_PERIODS - SAS_APPROX_STEPS;
  localparam int SAS_STAB_PERIODS = 16;
  // interrupt status bits
  localparam int SAS_IRQ_W = 2;
  localparam int SAS_IRQ_DONE = 0;
  localparam int SAS_IRQ_OVERRUN = 1;
  typedef enum logic [1:0] {SAS_OFF, SAS_STAB, SAS_LOAD, SAS_APPROX} sas_state_t;
endpackage

// file: rtl/sas_sequencer.sv
// Purpose: digital sequencer of an 8-bit SAR converter with a Wishbone register slave
// Assumes: comparator output is synchronous to REF_CLK and valid one converter period after DAC change
// Notes: completion flag clears on control/status read; the separate interrupt output is a system add-on
`timescale 1ns/1ps
module sas_sequencer
  import sas_pkg::*;
#(
  parameter int STAB_PERIODS = SAS_STAB_PERIODS
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [SAS_AW-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WB_ERR_O,
  // analog front end
  output logic [SAS_CH_W-1:0] CHANNEL_SELECT,
  output logic SAMPLE_CONNECT,
  output logic CONVERTER_POWER,
  output logic [7:0] DAC_CODE,
  input wire logic COMPARATOR_HIGH,
  // system
  input wire logic HALT_MODE,
  output logic IRQ
);
  sas_state_t state_reg;
  logic [1:0] div_reg;
  logic [3:0] phase_cnt_reg;
  logic [$clog2(STAB_PERIODS+1)-1:0] stab_cnt_reg;
  logic [7:0] trial_reg;
  logic [7:0] result_reg;
  logic on_reg;
  logic done_reg;
  logic [SAS_CH_W-1:0] ch_reg;
  logic [SAS_IRQ_W-1:0] irq_stat_reg;
  logic [SAS_IRQ_W-1:0] irq_mask_reg;
  logic ack_reg;
  logic err_reg;
  logic [31:0] rdata_reg;
  logic tick;
  logic conv_end;
  logic run;
  logic wb_req;
  logic wr_csr;
  logic rd_csr;
  logic rd_stat;
  logic addr_ok;
  logic [7:0] trial_next;
  logic [7:0] csr_view;

  assign wb_req = WB_CYC_I && WB_STB_I && !ack_reg && !err_reg;
  assign addr_ok = (WB_ADR_I == SAS_OFS_RESULT) || (WB_ADR_I == SAS_OFS_CSR) ||
                   (WB_ADR_I == SAS_OFS_IRQ_STAT) || (WB_ADR_I == SAS_OFS_IRQ_MASK);
  assign wr_csr = wb_req && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == SAS_OFS_CSR);
  assign rd_csr = wb_req && !WB_WE_I && (WB_ADR_I == SAS_OFS_CSR);
  assign rd_stat = wb_req && !WB_WE_I && (WB_ADR_I == SAS_OFS_IRQ_STAT);
  // halt acts as a forced off without touching the software bit
  assign run = on_reg && !HALT_MODE;
  assign tick = (div_reg == 2'(SAS_CLK_DIV - 1));
  assign conv_end = tick && (state_reg == SAS_APPROX) && (phase_cnt_reg == 4'(SAS_APPROX_STEPS - 1));

  // bit six and four are reserved and simply not stored
  always_comb begin
    csr_view = 8'h00;
    csr_view[SAS_CSR_DONE_BIT] = done_reg;
    csr_view[SAS_CSR_ON_BIT] = on_reg;
    csr_view[SAS_CSR_CH_LSB +: SAS_CH_W] = ch_reg;
  end

  // control bits
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      on_reg <= SAS_CSR_RESET[SAS_CSR_ON_BIT];
      ch_reg <= SAS_CSR_RESET[SAS_CSR_CH_LSB +: SAS_CH_W];
    end else if (wr_csr) begin
      on_reg <= WB_DAT_I[SAS_CSR_ON_BIT];
      ch_reg <= WB_DAT_I[SAS_CSR_CH_LSB +: SAS_CH_W];
    end
  end

  // completion flag: a conversion end in the read cycle wins over the clear
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      done_reg <= SAS_CSR_RESET[SAS_CSR_DONE_BIT];
    end else if (conv_end) begin
      done_reg <= 1'b1;
    end else if (rd_csr) begin
      done_reg <= 1'b0;
    end
  end

  // converter clock divider, restarted on every start so the first load is immediate
  always_ff @(posedge REF_CLK) begin
    if (!RST_B || !run || state_reg == SAS_OFF) begin
      div_reg <= 2'd0;
    end else begin
      div_reg <= tick ? 2'd0 : div_reg + 2'd1;
    end
  end

  // stabilisation countdown after halt wake-up
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      stab_cnt_reg <= '0;
    end else if (HALT_MODE) begin
      stab_cnt_reg <= ($bits(stab_cnt_reg))'(STAB_PERIODS);
    end else if (tick && state_reg == SAS_STAB && stab_cnt_reg != '0) begin
      stab_cnt_reg <= stab_cnt_reg - 1'b1;
    end
  end

  always_comb begin
    trial_next = trial_reg;
    // keep the tested bit only if the input is at or above the trial level
    if (!COMPARATOR_HIGH) begin
      trial_next[3'(SAS_APPROX_STEPS - 1) - phase_cnt_reg[2:0]] = 1'b0;
    end
    if (phase_cnt_reg != 4'(SAS_APPROX_STEPS - 1)) begin
      trial_next[3'(SAS_APPROX_STEPS - 2) - phase_cnt_reg[2:0]] = 1'b1;
    end
  end

  // phase sequencer
  always_ff @(posedge REF_CLK) begin
    if (!RST_B || !run) begin
      state_reg <= SAS_OFF;
      phase_cnt_reg <= 4'd0;
      trial_reg <= 8'h00;
    end else begin
      case (state_reg)
        SAS_OFF: begin
          state_reg <= (stab_cnt_reg != '0) ? SAS_STAB : SAS_LOAD;
          phase_cnt_reg <= 4'd0;
        end
        SAS_STAB: begin
          if (tick && stab_cnt_reg == '0) begin
            state_reg <= SAS_LOAD;
          end
        end
        SAS_LOAD: begin
          if (tick) begin
            if (phase_cnt_reg == 4'(SAS_LOAD_PERIODS - 1)) begin
              state_reg <= SAS_APPROX;
              phase_cnt_reg <= 4'd0;
              trial_reg <= 8'h80;
            end else begin
              phase_cnt_reg <= phase_cnt_reg + 4'd1;
            end
          end
        end
        SAS_APPROX: begin
          if (tick) begin
            trial_reg <= trial_next;
            if (conv_end) begin
              state_reg <= SAS_LOAD;
              phase_cnt_reg <= 4'd0;
            end else begin
              phase_cnt_reg <= phase_cnt_reg + 4'd1;
            end
          end
        end
        default: begin
          state_reg <= SAS_OFF;
        end
      endcase
    end
  end

  // result only changes at a conversion end; saturation needs no flag
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      result_reg <= SAS_RESULT_RESET;
    end else if (conv_end) begin
      result_reg <= trial_next;
    end
  end

  // interrupt status: end of conversion, and end while previous flag still unread
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      for (int i = 0; i < SAS_IRQ_W; i++) begin
        if (conv_end && (i == SAS_IRQ_DONE || done_reg)) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (rd_stat) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
      if (wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == SAS_OFS_IRQ_MASK) begin
        irq_mask_reg <= WB_DAT_I[SAS_IRQ_W-1:0];
      end
    end
  end

  // bus answer one cycle after the request; writes to the result are dropped
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req && addr_ok;
      err_reg <= wb_req && !addr_ok;
      if (wb_req && !WB_WE_I) begin
        case (WB_ADR_I)
          SAS_OFS_RESULT: rdata_reg <= {24'h00_0000, result_reg};
          SAS_OFS_CSR: rdata_reg <= {24'h00_0000, csr_view};
          SAS_OFS_IRQ_STAT: rdata_reg <= {30'h0000_0000, irq_stat_reg};
          SAS_OFS_IRQ_MASK: rdata_reg <= {30'h0000_0000, irq_mask_reg};
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_ERR_O = err_reg;
  assign WB_DAT_O = rdata_reg;
  assign CHANNEL_SELECT = ch_reg;
  assign SAMPLE_CONNECT = (state_reg == SAS_LOAD);
  assign CONVERTER_POWER = (state_reg != SAS_OFF);
  assign DAC_CODE = trial_reg;
  assign IRQ = |(irq_stat_reg & irq_mask_reg);
endmodule

// file: test/sas_sequencer_sva.sv
// Purpose: port checker for the converter sequencer
// Assumes: answer one cycle after a taken request
// Notes: one converter period is four clocks
`timescale 1ns/1ps
module sas_sequencer_sva
  import sas_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [SAS_AW-1:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  input wire logic SAMPLE_CONNECT,
  input wire logic CONVERTER_POWER,
  input wire logic [7:0] DAC_CODE,
  input wire logic HALT_MODE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // clocks since the last load began, kept only while power stays on, so a restart mid-conversion is not judged
  logic [5:0] load_age;
  always_ff @(posedge REF_CLK) begin
    if (!RST_B || !CONVERTER_POWER) begin
      load_age <= 6'h00;
    end else if ($rose(SAMPLE_CONNECT)) begin
      load_age <= 6'h01;
    end else if (load_age != 6'h00 && load_age != 6'h3F) begin
      load_age <= load_age + 6'h01;
    end
  end
  sequence s_load;
    $rose(SAMPLE_CONNECT);
  endsequence
  sequence s_comp;
    $fell(SAMPLE_CONNECT) && CONVERTER_POWER;
  endsequence
  sequence s_wr;
    WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_ADR_I == SAS_OFS_CSR;
  endsequence
  property p_load;
    s_load |-> SAMPLE_CONNECT[*8];
  endproperty
  a_load: assert property (p_load) else $error("load phase too short");
  property p_comp;
    s_comp |-> !SAMPLE_CONNECT[*8];
  endproperty
  a_comp: assert property (p_comp) else $error("capacitor connected while computing");
  property p_period;
    load_age == 6'h10 |-> !SAMPLE_CONNECT ##32 (SAMPLE_CONNECT || !CONVERTER_POWER || load_age != 6'h30);
  endproperty
  a_period: assert property (p_period) else $error("conversion not twelve periods");
  property p_dac;
    s_comp |-> DAC_CODE == 8'h80;
  endproperty
  a_dac: assert property (p_dac) else $error("first trial code wrong");
  property p_start;
    s_wr ##0 (WB_DAT_I[5] && !CONVERTER_POWER && !HALT_MODE) |-> ##2 SAMPLE_CONNECT;
  endproperty
  a_start: assert property (p_start) else $error("conversion did not start");
  property p_stop;
    s_wr ##0 (!WB_DAT_I[5] && CONVERTER_POWER) |-> ##2 !CONVERTER_POWER;
  endproperty
  a_stop: assert property (p_stop) else $error("converter not switched off");
  property p_halt;
    HALT_MODE |-> ##[1:2] !CONVERTER_POWER;
  endproperty
  a_halt: assert property (p_halt) else $error("halt left converter on");
  property p_ack;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("ack longer than one cycle");
endmodule
bind sas_sequencer sas_sequencer_sva u_sva (.REF_CLK(REF_CLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
  .SAMPLE_CONNECT(SAMPLE_CONNECT), .CONVERTER_POWER(CONVERTER_POWER), .DAC_CODE(DAC_CODE),
  .HALT_MODE(HALT_MODE));

// file: test/sas_afe_model.sv
// Purpose: analog front end: channel levels, sample hold, comparator
// Assumes: levels given in code units
// Notes: comparator answers at once, faster than a real one
`timescale 1ns/1ps
module sas_afe_model (
  input wire logic REF_CLK,
  input wire logic [3:0] CHANNEL_SELECT,
  input wire logic SAMPLE_CONNECT,
  input wire logic [7:0] DAC_CODE,
  input wire logic [7:0] LEVEL [16],
  output logic COMPARATOR_HIGH
);
  logic [7:0] held_reg;
  initial held_reg = 8'h00;
  // capacitor keeps its charge once disconnected
  always_ff @(posedge REF_CLK) begin
    if (SAMPLE_CONNECT) begin
      held_reg <= LEVEL[CHANNEL_SELECT];
    end
  end
  assign COMPARATOR_HIGH = held_reg >= DAC_CODE;
endmodule

// file: test/tb_sas_sequencer.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: stabilisation shortened to 4 periods
// Notes: expected results come from the level table
`timescale 1ns/1ps
module tb_sas_sequencer;
  import sas_pkg::*;
  logic clk, rst_b, cyc, stb, we, halt, ack, err, irq, conn, pwr, cmp, e;
  logic [3:0] adr, ch;
  logic [31:0] wdat, rdat, q;
  logic [7:0] dac;
  logic [7:0] lvl [16];
  int err_count, cmp_count, seed, n;
  sas_sequencer #(.STAB_PERIODS(4)) u_sas_sequencer (.REF_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .WB_ERR_O(err), .CHANNEL_SELECT(ch), .SAMPLE_CONNECT(conn), .CONVERTER_POWER(pwr),
    .DAC_CODE(dac), .COMPARATOR_HIGH(cmp), .HALT_MODE(halt), .IRQ(irq));
  sas_afe_model u_sas_afe_model (.REF_CLK(clk), .CHANNEL_SELECT(ch), .SAMPLE_CONNECT(conn),
    .DAC_CODE(dac), .LEVEL(lvl), .COMPARATOR_HIGH(cmp));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string name, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, x, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (!(ack || err) && k < 50);
    q = rdat;
    e = err;
    if (k == 50) err_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run;
  end
  initial begin
    {cyc, stb, we, halt, rst_b} = '0;
    adr = '0;
    wdat = '0;
    seed = 97329;
    for (int i = 0; i < 16; i++) lvl[i] = 8'($random(seed));
    lvl[0] = 8'h00;
    lvl[15] = 8'hFF;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(0, SAS_OFS_RESULT, 0);
    chk("result", 0, q);
    bus(0, SAS_OFS_CSR, 0);
    chk("csr", 0, q);
    bus(1, SAS_OFS_RESULT, 8'h5A);
    bus(0, SAS_OFS_RESULT, 0);
    chk("result", 0, q);
    bus(0, 4'h2, 0);
    chk("err", 1, e);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      bus(1, SAS_OFS_CSR, 8'(c));
      chk("channel", c, ch);
      bus(1, SAS_OFS_CSR, 8'(c) | 8'h20);
      n = 0;
      do bus(0, SAS_OFS_CSR, 0); while (!q[7] && ++n < 40);
      chk("csr", 32'hA0 | c, q);
      bus(0, SAS_OFS_CSR, 0);
      chk("csr", 32'h20 | c, q);
      bus(0, SAS_OFS_RESULT, 0);
      chk("result", {24'h0, lvl[c]}, q);
    end
    chk("irq", 0, irq);
    $display("test channels done");
    bus(1, SAS_OFS_IRQ_MASK, 8'h01);
    n = 0;
    while (!irq && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("irq", 1, irq);
    bus(0, SAS_OFS_IRQ_STAT, 0);
    chk("stat", 1, q[0]);
    chk("irq", 0, irq);
    bus(1, SAS_OFS_IRQ_MASK, 8'h00);
    $display("test irq done");
    halt <= 1'b1;
    repeat (2) @(posedge clk);
    chk("power", 0, pwr);
    bus(1, SAS_OFS_CSR, 8'h0F);
    halt <= 1'b0;
    bus(0, SAS_OFS_RESULT, 0);
    chk("result", {24'h0, lvl[15]}, q);
    $display("test halt done");
    complete_run;
  end
endmodule
